// ### design/lbp_core.sv
// led pwm unit: registers, duty limits, blink and breathing engine
// Contract
// - writing one sets commit-request, zero leaves it, always readable
// - hardware clears commit-request after the period-end parameter copy
// - delay, step, interval writes stay held until commit at period end
// - size field 0,1,2 selects 8,7,6-bit resolution; 3 reserved
// - any synchronize-hold bit holds all counters at initial values
// - counters run only when every synchronize-hold bit is zero
// - in blink, base-clock bit picks system clock or 32.768 kHz clock
// - mode 3 on, 2 blink, 1 breathe, 0 off
// - mode off zeroes internal registers and counters, gating them
// - duty-limit writes held, moved to operating copy at period end
// - upper and lower limit bytes written independently
// - duty-limit reads return the operating values
// - breathing at or over upper limit holds high delay, then falls
// - breathing at or under lower limit holds low delay, then rises
// - blink uses the lower-limit byte as the duty cycle
// - period counts zero to top (ff, fe, fc) and ends on wrap
// - limit holding copy moves every period even after one byte
`timescale 1ns/1ps
`default_nettype none
`include "lbp_cfg.svh"
module lbp_core
   import lbp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [`LBP_AW-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [`LBP_AW-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic slow_clk_pin,
   input wire logic other_sync_hold,
   output logic sync_hold_out,
   output logic led_out
);
   lbp_core_t c_ff, nxt_c;
   lbp_wr_t wr;
   logic [`LBP_AW-1:0] rd_addr;
   logic [31:0] rd_data;
   logic [7:0] top;
   logic hold_all;
   logic running;
   logic adv;
   logic pend;
   logic slow_tick;
   logic cfg_wr;

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   lbp_axil_slave u_bus (
      .clk(clk),
      .reset_n(reset_n),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr(wr),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

   // read mux
   always_comb begin
      if (rd_addr == `LBP_OFF_CFG) begin
         rd_data = {25'h0, c_ff.commit, c_ff.size, c_ff.sync_hold,
            c_ff.clksrc, c_ff.mode};
      end else if (rd_addr == `LBP_OFF_LIM) begin
         rd_data = {16'h0, c_ff.lim_op};
      end else if (rd_addr == `LBP_OFF_DLY) begin
         rd_data = c_ff.dly_op;
      end else if (rd_addr == `LBP_OFF_STEP) begin
         rd_data = c_ff.step_op;
      end else if (rd_addr == `LBP_OFF_IVL) begin
         rd_data = c_ff.ivl_op;
      end else begin
         rd_data = 32'h0;
      end
   end

   // ---------------------------------------------------------------
   // timing terms
   // ---------------------------------------------------------------
   // top value per counter width
   always_comb begin
      case (c_ff.size)
         2'h1: top = `LBP_TOP_7;
         2'h2: top = `LBP_TOP_6;
         default: top = `LBP_TOP_8;
      endcase
   end

   assign cfg_wr = wr.en && wr.addr == `LBP_OFF_CFG && wr.strb[0];
   assign hold_all = c_ff.sync_hold || other_sync_hold;
   assign running = c_ff.mode == LBP_BREATHE || c_ff.mode == LBP_BLINK;
   assign slow_tick = c_ff.slow_s2 && !c_ff.slow_prev;
   // slow base clock only in blink with source zero
   assign adv = (c_ff.mode == LBP_BLINK && !c_ff.clksrc) ? slow_tick : 1'b1;
   // period ends when the counter wraps from top
   assign pend = running && !hold_all && adv && c_ff.cnt == top;
   assign sync_hold_out = c_ff.sync_hold;
   assign led_out = c_ff.led;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [8:0] step;
      logic [8:0] sum;
      logic [7:0] eff;
      step = 9'h0;
      sum = 9'h0;
      eff = 8'h0;
      nxt_c = c_ff;
      nxt_c.slow_s1 = slow_clk_pin;
      nxt_c.slow_s2 = c_ff.slow_s1;
      nxt_c.slow_prev = c_ff.slow_s2;
      if (cfg_wr) begin
         nxt_c.mode = wr.data[`LBP_F_MODE];
         nxt_c.clksrc = wr.data[`LBP_B_CLKSRC];
         nxt_c.sync_hold = wr.data[`LBP_B_SYNC];
         nxt_c.size = wr.data[`LBP_F_SIZE];
      end
      // byte lanes of the limit holding copy
      if (wr.en && wr.addr == `LBP_OFF_LIM) begin
         nxt_c.lim_hold = 16'(lbp_merge({16'h0, c_ff.lim_hold}, wr.data,
            wr.strb));
      end
      // breathing parameters land in holding copies
      if (wr.en && wr.addr == `LBP_OFF_DLY) begin
         nxt_c.dly_hold = lbp_merge(c_ff.dly_hold, wr.data, wr.strb);
      end
      if (wr.en && wr.addr == `LBP_OFF_STEP) begin
         nxt_c.step_hold = lbp_merge(c_ff.step_hold, wr.data, wr.strb);
      end
      if (wr.en && wr.addr == `LBP_OFF_IVL) begin
         nxt_c.ivl_hold = lbp_merge(c_ff.ivl_hold, wr.data, wr.strb);
      end
      if (c_ff.mode == LBP_OFF) begin
         // off: engine state and operating copies zeroed
         nxt_c.cnt = 8'h0;
         nxt_c.duty = 8'h0;
         nxt_c.phase = LBP_RISE;
         nxt_c.hold_cnt = 12'h0;
         nxt_c.ivl_cnt = 4'h0;
         nxt_c.lim_op = 16'h0;
         nxt_c.dly_op = 32'h0;
         nxt_c.step_op = 32'h0;
         nxt_c.ivl_op = 32'h0;
      end else if (hold_all) begin
         nxt_c.cnt = 8'h0;
         nxt_c.duty = 8'h0;
         nxt_c.phase = LBP_RISE;
         nxt_c.hold_cnt = 12'h0;
         nxt_c.ivl_cnt = 4'h0;
      end else if (running && adv) begin
         nxt_c.cnt = (c_ff.cnt == top) ? 8'h0 : c_ff.cnt + 8'h1;
      end
      if (cfg_wr && wr.data[`LBP_F_SIZE] != c_ff.size) begin
         nxt_c.cnt = 8'h0;
      end
      if (pend) begin
         nxt_c.lim_op = c_ff.lim_hold;
         if (c_ff.commit) begin
            nxt_c.dly_op = c_ff.dly_hold;
            nxt_c.step_op = c_ff.step_hold;
            nxt_c.ivl_op = c_ff.ivl_hold;
         end
      end
      if (pend && c_ff.mode == LBP_BREATHE) begin
         step = {5'h0, c_ff.step_op[3:0]} + 9'h1;
         case (c_ff.phase)
            LBP_RISE: begin
               // upper limit reached: start the high hold
               if (c_ff.duty >= c_ff.lim_op[`LBP_F_UPPER]) begin
                  nxt_c.phase = LBP_HOLD_HI;
                  nxt_c.hold_cnt = c_ff.dly_op[`LBP_F_HIGH_DLY];
               end else if (c_ff.ivl_cnt != c_ff.ivl_op[3:0]) begin
                  nxt_c.ivl_cnt = c_ff.ivl_cnt + 4'h1;
               end else begin
                  nxt_c.ivl_cnt = 4'h0;
                  sum = {1'b0, c_ff.duty} + step;
                  nxt_c.duty = sum[8] ? 8'hff : sum[7:0];
               end
            end
            LBP_HOLD_HI: begin
               if (c_ff.hold_cnt == 12'h0) begin
                  nxt_c.phase = LBP_FALL;
               end else begin
                  nxt_c.hold_cnt = c_ff.hold_cnt - 12'h1;
               end
            end
            LBP_FALL: begin
               // lower limit reached: start the low hold
               if (c_ff.duty <= c_ff.lim_op[`LBP_F_LOWER]) begin
                  nxt_c.phase = LBP_HOLD_LO;
                  nxt_c.hold_cnt = c_ff.dly_op[`LBP_F_LOW_DLY];
               end else if (c_ff.ivl_cnt != c_ff.ivl_op[3:0]) begin
                  nxt_c.ivl_cnt = c_ff.ivl_cnt + 4'h1;
               end else begin
                  nxt_c.ivl_cnt = 4'h0;
                  sum = {1'b0, c_ff.duty} - step;
                  nxt_c.duty = sum[8] ? 8'h00 : sum[7:0];
               end
            end
            default: begin
               if (c_ff.hold_cnt == 12'h0) begin
                  nxt_c.phase = LBP_RISE;
               end else begin
                  nxt_c.hold_cnt = c_ff.hold_cnt - 12'h1;
               end
            end
         endcase
      end
      // set by a one, cleared by hardware; a set wins
      if (cfg_wr && wr.data[`LBP_B_COMMIT]) begin
         nxt_c.commit = 1'b1;
      end else if (pend && c_ff.commit) begin
         nxt_c.commit = 1'b0;
      end
      // blink duty is the lower limit byte
      eff = (c_ff.mode == LBP_BLINK) ? c_ff.lim_op[`LBP_F_LOWER] : c_ff.duty;
      // led active while the counter is below duty
      nxt_c.led = (c_ff.mode == LBP_ON) || (running && c_ff.cnt < eff);
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         c_ff <= '0;
      end else begin
         c_ff <= nxt_c;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_hi_reached;
      pend && c_ff.mode == LBP_BREATHE && c_ff.phase == LBP_RISE &&
         c_ff.duty >= c_ff.lim_op[`LBP_F_UPPER];
   endsequence
   sequence s_lo_reached;
      pend && c_ff.mode == LBP_BREATHE && c_ff.phase == LBP_FALL &&
         c_ff.duty <= c_ff.lim_op[`LBP_F_LOWER];
   endsequence

   commit_set_a: assert property (
      cfg_wr && wr.data[`LBP_B_COMMIT] |=> c_ff.commit)
      else $error("commit request not set by write");
   commit_clr_a: assert property (
      pend && c_ff.commit && !cfg_wr |=> !c_ff.commit &&
         c_ff.dly_op == $past(c_ff.dly_hold))
      else $error("commit request not cleared after copy");
   hold_keep_a: assert property (
      c_ff.mode != LBP_OFF && !c_ff.commit |=> $stable(c_ff.step_op))
      else $error("step copy moved without commit");
   cnt_top_a: assert property (
      running |-> c_ff.cnt <= top)
      else $error("counter passed its top value");
   sync_park_a: assert property (
      hold_all ##1 hold_all |-> c_ff.cnt == 8'h0 && c_ff.duty == 8'h0)
      else $error("counter moved during synchronize hold");
   off_zero_a: assert property (
      c_ff.mode == LBP_OFF ##1 c_ff.mode == LBP_OFF |-> c_ff.cnt == 8'h0
         && c_ff.lim_op == 16'h0 && !led_out)
      else $error("off mode left state alive");
   lim_xfer_a: assert property (
      pend |=> c_ff.lim_op == $past(c_ff.lim_hold))
      else $error("limit holding copy not transferred");
   hi_hold_a: assert property (
      s_hi_reached |=> c_ff.phase == LBP_HOLD_HI &&
         c_ff.hold_cnt == $past(c_ff.dly_op[`LBP_F_HIGH_DLY]))
      else $error("high hold not entered");
   lo_hold_a: assert property (
      s_lo_reached |=> c_ff.phase == LBP_HOLD_LO &&
         c_ff.hold_cnt == $past(c_ff.dly_op[`LBP_F_LOW_DLY]))
      else $error("low hold not entered");
   led_on_a: assert property (
      c_ff.mode == LBP_ON |=> led_out)
      else $error("always-on mode not driving led");
   blink_out_a: assert property (
      c_ff.mode == LBP_BLINK |=> led_out ==
         ($past(c_ff.cnt) < $past(c_ff.lim_op[`LBP_F_LOWER])))
      else $error("blink duty not from lower limit");
endmodule
`default_nettype wire

// ### include/lbp_cfg.svh
// offsets, field positions, response codes and timing counts of the led pwm
`ifndef LBP_CFG_SVH
`define LBP_CFG_SVH
`define LBP_AW 8
`define LBP_OFF_CFG 8'h00
`define LBP_OFF_LIM 8'h04
`define LBP_OFF_DLY 8'h08
`define LBP_OFF_STEP 8'h0c
`define LBP_OFF_IVL 8'h10
`define LBP_F_MODE 1:0
`define LBP_B_CLKSRC 2
`define LBP_B_SYNC 3
`define LBP_F_SIZE 5:4
`define LBP_B_COMMIT 6
`define LBP_F_UPPER 15:8
`define LBP_F_LOWER 7:0
`define LBP_F_HIGH_DLY 23:12
`define LBP_F_LOW_DLY 11:0
`define LBP_TOP_8 8'hff
`define LBP_TOP_7 8'hfe
`define LBP_TOP_6 8'hfc
`define LBP_RESP_OK 2'h0
`define LBP_RESP_ERR 2'h2
`endif

// ### include/lbp_pkg.sv
// types shared by the led pwm register slave and core
`include "lbp_cfg.svh"
package lbp_pkg;
   typedef enum logic [1:0] {LBP_OFF, LBP_BREATHE, LBP_BLINK, LBP_ON} lbp_mode_t;
   typedef enum logic [1:0] {LBP_RISE, LBP_HOLD_HI, LBP_FALL, LBP_HOLD_LO}
      lbp_phase_t;
   // one register write handed from the bus slave to the core
   typedef struct packed {
      logic en;
      logic [`LBP_AW-1:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } lbp_wr_t;
   // bus slave state
   typedef struct packed {
      logic aw_have;
      logic w_have;
      logic [`LBP_AW-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lbp_bus_t;
   // core state
   typedef struct packed {
      logic [1:0] mode;
      logic clksrc;
      logic sync_hold;
      logic [1:0] size;
      logic commit;
      logic [15:0] lim_hold;
      logic [15:0] lim_op;
      logic [31:0] dly_hold;
      logic [31:0] dly_op;
      logic [31:0] step_hold;
      logic [31:0] step_op;
      logic [31:0] ivl_hold;
      logic [31:0] ivl_op;
      logic [7:0] cnt;
      logic [7:0] duty;
      lbp_phase_t phase;
      logic [11:0] hold_cnt;
      logic [3:0] ivl_cnt;
      logic slow_s1;
      logic slow_s2;
      logic slow_prev;
      logic led;
   } lbp_core_t;
   // true for every mapped register word
   function automatic logic lbp_hit(input logic [`LBP_AW-1:0] a);
      return a == `LBP_OFF_CFG || a == `LBP_OFF_LIM || a == `LBP_OFF_DLY ||
         a == `LBP_OFF_STEP || a == `LBP_OFF_IVL;
   endfunction
   // byte-lane merge of a write into a stored word
   function automatic logic [31:0] lbp_merge(input logic [31:0] old,
      input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// ### design/lbp_axil_slave.sv
// axi4-lite slave front end for the led pwm registers
`timescale 1ns/1ps
`default_nettype none
`include "lbp_cfg.svh"
module lbp_axil_slave
   import lbp_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [`LBP_AW-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [`LBP_AW-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   output lbp_wr_t wr,
   output logic [`LBP_AW-1:0] rd_addr,
   input wire logic [31:0] rd_data
);
   lbp_bus_t s_ff, nxt_s;

   // ---------------------------------------------------------------
   // handshakes and outputs
   // ---------------------------------------------------------------
   assign s_awready = !s_ff.aw_have && !s_ff.bvalid;
   assign s_wready = !s_ff.w_have && !s_ff.bvalid;
   assign s_arready = !s_ff.rvalid;
   assign s_bvalid = s_ff.bvalid;
   assign s_bresp = s_ff.bresp;
   assign s_rvalid = s_ff.rvalid;
   assign s_rdata = s_ff.rdata;
   assign s_rresp = s_ff.rresp;
   assign rd_addr = s_araddr;
   // write issued to a mapped register once address and data are both held
   assign wr = {s_ff.aw_have && s_ff.w_have && lbp_hit(s_ff.awaddr),
      s_ff.awaddr, s_ff.wdata, s_ff.wstrb};

   // next state: address and data taken in either order
   always_comb begin
      nxt_s = s_ff;
      if (s_awvalid && s_awready) begin
         nxt_s.aw_have = 1'b1;
         nxt_s.awaddr = s_awaddr;
      end
      if (s_wvalid && s_wready) begin
         nxt_s.w_have = 1'b1;
         nxt_s.wdata = s_wdata;
         nxt_s.wstrb = s_wstrb;
      end
      if (s_ff.aw_have && s_ff.w_have) begin
         nxt_s.aw_have = 1'b0;
         nxt_s.w_have = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = lbp_hit(s_ff.awaddr) ? `LBP_RESP_OK : `LBP_RESP_ERR;
      end else if (s_ff.bvalid && s_bready) begin
         nxt_s.bvalid = 1'b0;
      end
      if (s_arvalid && s_arready) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = rd_data;
         nxt_s.rresp = lbp_hit(s_araddr) ? `LBP_RESP_OK : `LBP_RESP_ERR;
      end else if (s_ff.rvalid && s_rready) begin
         nxt_s.rvalid = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule
`default_nettype wire

// ### sim/lbp_led_model.sv
// led partner: watches the pwm pin, counts lit cycles and measures period
`timescale 1ns/1ps
`default_nettype none
module lbp_led_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic led_in,
   input wire logic clr,
   output logic [15:0] rises,
   output logic [15:0] period,
   output logic [15:0] high
);
   logic prev_ff;
   logic [15:0] since_ff;
   // -------------------------------------------------------------
   // light meter
   // -------------------------------------------------------------
   // period runs across clears so a window always sees the true spacing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prev_ff <= 1'b0;
         since_ff <= 16'h0;
         rises <= 16'h0;
         period <= 16'h0;
         high <= 16'h0;
      end else begin
         prev_ff <= led_in;
         since_ff <= (led_in && !prev_ff) ? 16'h1 : since_ff + 16'h1;
         if (led_in && !prev_ff) begin
            period <= since_ff;
         end
         if (clr) begin
            rises <= 16'h0;
            high <= 16'h0;
         end else begin
            rises <= rises + {15'h0, led_in && !prev_ff};
            high <= high + {15'h0, led_in};
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/led_breathing_pwm_config_tb_top.sv
// self-checking bench for the led pwm register block
`timescale 1ns/1ps
`default_nettype none
module led_breathing_pwm_config_tb_top
   import lbp_pkg::*;
;
   logic clk, reset_n, slow_clk_pin, slow_run, other_sync_hold, clr;
   logic sync_hold_out, led_out;
   logic [7:0] s_awaddr, s_araddr;
   logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   logic [15:0] rises, period, high;
   int n_mismatch, num_checks, cyc, p;
   logic [7:0] tops [4] = '{8'hff, 8'hfe, 8'hfc, 8'hff};

   lbp_core i_dut (.clk(clk), .reset_n(reset_n), .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
      .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
      .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
      .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
      .s_rready(s_rready), .slow_clk_pin(slow_clk_pin),
      .other_sync_hold(other_sync_hold), .sync_hold_out(sync_hold_out),
      .led_out(led_out));
   lbp_led_model i_led (.clk(clk), .reset_n(reset_n), .led_in(led_out),
      .clr(clr), .rises(rises), .period(period), .high(high));

   // -------------------------------------------------------------
   // clocks and timeout
   // -------------------------------------------------------------
   always #2 clk = ~clk;
   // slow pin toggles only while a scenario asks for it
   always #20 if (slow_run) slow_clk_pin = ~slow_clk_pin;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what,
            seen, exp);
      end
   endtask
   // handshakes are judged at the falling edge, acted on at the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
      logic aw_go, w_go, done;
      logic [1:0] r;
      done = 1'b0;
      @(posedge clk);
      s_awaddr <= a;
      s_awvalid <= 1'b1;
      s_wdata <= d;
      s_wstrb <= s;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         aw_go = s_awvalid && s_awready;
         w_go = s_wvalid && s_wready;
         done = s_bvalid;
         r = s_bresp;
         @(posedge clk);
         if (aw_go) s_awvalid <= 1'b0;
         if (w_go) s_wvalid <= 1'b0;
         if (done) s_bready <= 1'b0;
      end
      chk({30'h0, r}, {30'h0, er}, "write response");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er);
      logic ar_go, done;
      logic [1:0] r;
      logic [31:0] d;
      done = 1'b0;
      @(posedge clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         ar_go = s_arvalid && s_arready;
         done = s_rvalid;
         r = s_rresp;
         d = s_rdata;
         @(posedge clk);
         if (ar_go) s_arvalid <= 1'b0;
         if (done) s_rready <= 1'b0;
      end
      chk({30'h0, r}, {30'h0, er}, "read response");
      chk(d, ed, "read data");
   endtask
   // clears the light meter, then lets n cycles pass
   task automatic measure(input int n);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      clk = 0; reset_n = 0; slow_clk_pin = 0; slow_run = 0; clr = 0;
      other_sync_hold = 0; s_awaddr = 0; s_awvalid = 0; s_wdata = 0;
      s_wstrb = 0; s_wvalid = 0; s_bready = 0; s_araddr = 0;
      s_arvalid = 0; s_rready = 0; n_mismatch = 0; num_checks = 0; cyc = 0;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h00, 32'h0, 2'h0);
      rd(8'h04, 32'h0, 2'h0);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h20, 32'h1, 4'hf, 2'h2);
      // commit request set while idle, then cleared by a period end
      wr(8'h08, 32'h300f, 4'hf, 2'h0);
      wr(8'h00, 32'h40, 4'h1, 2'h0);
      rd(8'h00, 32'h40, 2'h0);
      wr(8'h00, 32'h06, 4'h1, 2'h0);
      rd(8'h00, 32'h46, 2'h0);
      repeat (300) @(posedge clk);
      rd(8'h00, 32'h06, 2'h0);
      rd(8'h08, 32'h300f, 2'h0);
      wr(8'h08, 32'h100a, 4'hf, 2'h0);
      wr(8'h04, 32'h10, 4'h1, 2'h0);
      repeat (300) @(posedge clk);
      rd(8'h08, 32'h300f, 2'h0);
      rd(8'h04, 32'h10, 2'h0);
      wr(8'h00, 32'h0e, 4'h1, 2'h0);
      chk({31'h0, sync_hold_out}, 32'h1, "hold bit out");
      wr(8'h04, 32'h40, 4'h1, 2'h0);
      rd(8'h04, 32'h10, 2'h0);
      measure(600);
      chk({16'h0, rises}, 32'h0, "held led");
      wr(8'h00, 32'h06, 4'h1, 2'h0);
      repeat (300) @(posedge clk);
      rd(8'h04, 32'h40, 2'h0);
      other_sync_hold <= 1'b1;
      measure(600);
      chk({16'h0, rises}, 32'h0, "peer held led");
      other_sync_hold <= 1'b0;
      measure(600);
      chk({31'h0, rises != 16'h0}, 32'h1, "released led");
      wr(8'h04, 32'h8000, 4'h2, 2'h0);
      repeat (300) @(posedge clk);
      rd(8'h04, 32'h8040, 2'h0);
      // period length and lit time for every size code
      for (int i = 0; i < 4; i++) begin
         p = int'(tops[i]) + 1;
         wr(8'h00, 32'h06 | (i << 4), 4'h1, 2'h0);
         repeat (600) @(posedge clk);
         measure(2 * p);
         chk({16'h0, period}, p, "period");
         chk({16'h0, high}, 32'd128, "lit cycles");
      end
      // slow base clock, one tick every ten system cycles
      wr(8'h00, 32'h22, 4'h1, 2'h0);
      slow_run <= 1'b1;
      repeat (3000) @(posedge clk);
      measure(5060);
      chk({16'h0, period}, 32'd2530, "slow period");
      chk({16'h0, high}, 32'd1280, "slow lit cycles");
      slow_run <= 1'b0;
      wr(8'h00, 32'h03, 4'h1, 2'h0);
      measure(100);
      chk({16'h0, high}, 32'd100, "always on");
      wr(8'h00, 32'h00, 4'h1, 2'h0);
      measure(100);
      chk({16'h0, high}, 32'd0, "always off");
      rd(8'h04, 32'h0, 2'h0);
      // breathing, 6-bit: steps of four between limits 4 and 8,
      // high delay 1 and low delay 2 give a nine-period cycle
      wr(8'h08, 32'h1002, 4'hf, 2'h0);
      wr(8'h0c, 32'h3, 4'hf, 2'h0);
      wr(8'h04, 32'h0804, 4'h3, 2'h0);
      wr(8'h00, 32'h61, 4'h1, 2'h0);
      repeat (2600) @(posedge clk);
      measure(2277);
      chk({16'h0, period}, 32'd253, "breathing period");
      chk({16'h0, high}, 32'd52, "breathing lit cycles");
      chk({31'h0, sync_hold_out}, 32'h0, "hold bit out");
      stop_test();
   end
endmodule
`default_nettype wire
